/* File: ltd_pkg.sv */
/*
  shared constants and carriers of the logic and transfer decoder.
  assumes one system clock; operand fetch and write-back live outside.
*/
package ltd_pkg;

  // opcode rows whose low nibble 8..F names a bank register
  localparam logic [3:0] ROW_OR       = 4'h4;
  localparam logic [3:0] ROW_AND      = 4'h5;
  localparam logic [3:0] ROW_XOR      = 4'h6;
  localparam logic [3:0] ROW_IMM_REG  = 4'h7;
  localparam logic [3:0] ROW_REG_DIR  = 4'h8;
  localparam logic [3:0] ROW_DIR_REG  = 4'hA;
  localparam logic [3:0] ROW_TRADE    = 4'hC;
  localparam logic [3:0] ROW_LOAD_ACC = 4'hE;
  localparam logic [3:0] ROW_STORE    = 4'hF;

  // low nibbles shared by the logic rows (row 4, 5, 6)
  localparam logic [3:0] COL_DIR_ACC  = 4'h2;
  localparam logic [3:0] COL_DIR_IMM  = 4'h3;
  localparam logic [3:0] COL_ACC_IMM  = 4'h4;
  localparam logic [3:0] COL_ACC_DIR  = 4'h5;
  localparam logic [2:0] COL_IND_HI   = 3'h3;   // 6 and 7 share bits 3:1

  localparam logic [7:0] OP_ZERO_ACC  = 8'hE4;
  localparam logic [7:0] OP_INV_ACC   = 8'hF4;
  localparam logic [7:0] OP_SWAP_ACC  = 8'hC4;
  localparam logic [7:0] OP_RL        = 8'h23;
  localparam logic [7:0] OP_RLC       = 8'h33;
  localparam logic [7:0] OP_RR        = 8'h03;
  localparam logic [7:0] OP_RRC       = 8'h13;
  localparam logic [7:0] OP_LOAD_DIR  = 8'hE5;
  localparam logic [7:0] OP_LOAD_IMM  = 8'h74;
  localparam logic [7:0] OP_DIR_ACC   = 8'hF5;
  localparam logic [7:0] OP_DIR_DIR   = 8'h85;
  localparam logic [7:0] OP_DIR_IMM   = 8'h75;
  localparam logic [6:0] OP_DIR_IND   = 7'h43;  // 86, 87
  localparam logic [6:0] OP_IND_ACC   = 7'h7B;  // F6, F7
  localparam logic [6:0] OP_IND_DIR   = 7'h53;  // A6, A7
  localparam logic [6:0] OP_IND_IMM   = 7'h3B;  // 76, 77
  localparam logic [7:0] OP_DATA_POINTER16_IMM  = 8'h90;
  localparam logic [7:0] OP_CODE_DATA_POINTER16 = 8'h93;
  localparam logic [7:0] OP_CODE_PC   = 8'h83;
  localparam logic [7:0] OP_EXT_RD_R0 = 8'hEB;
  localparam logic [7:0] OP_EXT_RD_R1 = 8'hE3;
  localparam logic [7:0] OP_EXT_RD_DP = 8'hE0;
  localparam logic [6:0] OP_EXT_WR_RI = 7'h79;  // F2, F3
  localparam logic [7:0] OP_EXT_WR_DP = 8'hF0;
  localparam logic [7:0] OP_PUSH      = 8'hC0;
  localparam logic [7:0] OP_POP       = 8'hD0;
  localparam logic [7:0] OP_TRADE_DIR = 8'hC5;
  localparam logic [6:0] OP_TRADE_IND = 7'h63;  // C6, C7
  localparam logic [6:0] OP_DIGIT_IND = 7'h6B;  // D6, D7
  localparam logic [6:0] OP_LOAD_IND  = 7'h73;  // E6, E7

  // direct address at which the accumulator itself answers
  localparam logic [7:0] ACC_DIRECT_ADDR = 8'hE0;
  localparam int unsigned MC_CLKS = 1;          // clocks per machine cycle

  typedef enum logic [3:0] {
    ALU_PASS  = 4'h0,
    ALU_AND   = 4'h1,
    ALU_OR    = 4'h2,
    ALU_XOR   = 4'h3,
    ALU_ZERO  = 4'h4,
    ALU_INV   = 4'h5,
    ALU_RL    = 4'h6,
    ALU_RLC   = 4'h7,
    ALU_RR    = 4'h8,
    ALU_RRC   = 4'h9,
    ALU_SWAP  = 4'hA,
    ALU_TRADE = 4'hB,
    ALU_DIGIT = 4'hC
  } ltd_alu_op_t;

  typedef enum logic [3:0] {
    LOC_NONE  = 4'h0,
    LOC_ACC   = 4'h1,
    LOC_BANK  = 4'h2,
    LOC_DIR   = 4'h3,
    LOC_IND   = 4'h4,
    LOC_IMM   = 4'h5,
    LOC_CODE  = 4'h6,
    LOC_EXT8  = 4'h7,
    LOC_EXT16 = 4'h8,
    LOC_STACK = 4'h9,
    LOC_DATA_POINTER16  = 4'hA
  } ltd_loc_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte2;
    logic [7:0] byte3;
  } ltd_insn_t;

  typedef struct packed {
    logic [7:0]  acc;
    logic        carry;
    logic [7:0]  src_val;
    logic [7:0]  dst_val;
    logic [7:0]  ptr_val;
    logic [15:0] data_pointer16;
    logic [15:0] pc;
  } ltd_opnd_t;

  typedef struct packed {
    logic        legal;
    logic [1:0]  len;
    logic [1:0]  cycles;
    ltd_alu_op_t alu_op;
    ltd_loc_t    src;
    ltd_loc_t    dst;
    logic [2:0]  bank_idx;
    logic        ptr_sel;
    logic [7:0]  src_addr;
    logic [7:0]  dst_addr;
    logic [7:0]  imm;
  } ltd_dec_t;

  typedef struct packed {
    logic        acc_we;
    logic [7:0]  acc_val;
    logic        carry_we;
    logic        carry_val;
    logic        dst_we;
    logic [7:0]  dst_val;
    logic        data_pointer16_we;
    logic [15:0] data_pointer16_val;
    logic [15:0] mem_addr;
  } ltd_res_t;

endpackage : ltd_pkg

/* File: ltd_alu.sv */
/*
  byte operation unit of the decoder: logic, rotate, swap and trade.
  assumes a is the destination operand and b the source operand.
*/
`timescale 1ns/1ns
module ltd_alu
  import ltd_pkg::*;
(
  input  wire ltd_alu_op_t op,
  input  wire logic [7:0]  a,
  input  wire logic [7:0]  b,
  input  wire logic        carry_in,
  output logic [7:0]       result,
  output logic [7:0]       back,
  output logic             carry_out
);

  always_comb
  begin
    result    = a;
    back      = b;
    carry_out = carry_in;
    case (op)
      ALU_PASS:  result = b;
      ALU_AND:   result = a & b;
      ALU_OR:    result = a | b;
      ALU_XOR:   result = a ^ b;
      ALU_ZERO:  result = 8'h00;
      ALU_INV:   result = ~a;
      ALU_RL:    result = {a[6:0], a[7]};
      ALU_RLC:
      begin
        result    = {a[6:0], carry_in};
        carry_out = a[7];
      end
      ALU_RR:    result = {a[0], a[7:1]};
      ALU_RRC:
      begin
        result    = {carry_in, a[7:1]};
        carry_out = a[0];
      end
      ALU_SWAP:  result = {a[3:0], a[7:4]};
      ALU_TRADE:
      begin
        result = b;
        back   = a;
      end
      ALU_DIGIT:
      begin
        result = {a[7:4], b[3:0]};
        back   = {b[7:4], a[3:0]};
      end
      default:   result = a;
    endcase
  end

endmodule : ltd_alu

/* File: ltd_decoder.sv */
/*
  decoder and executer of the logic and data transfer instruction groups.
  assumes the caller presents all instruction bytes and fetched operands
  together, and holds them until in_ready; write-back is done outside.
*/
// Contract
// - and_logic into accumulator from register, direct, indirect, immediate; one cycle.
// - and_logic into direct byte: 52 accumulator source, 53 immediate source.
// - or_logic into accumulator from register, direct, indirect, immediate; one cycle.
// - or_logic into direct byte: 42 accumulator source, 43 immediate source.
// - xor_logic into accumulator from register, direct, indirect, immediate; one cycle.
// - xor_logic into direct byte: 62 accumulator source, 63 immediate source.
// - E4 zeroes, F4 inverts, C4 swaps accumulator nibbles; one byte, one cycle.
// - 23 rotates left plain, 33 rotates left through carry; one cycle.
// - 03 rotates right plain, 13 rotates right through carry; one cycle.
// - accumulator loads from register, direct, indirect or immediate in one cycle.
// - bank register written from accumulator, direct byte or immediate byte.
// - direct byte written from accumulator, register, direct, indirect or immediate.
// - indirect location written from accumulator, direct byte or immediate byte.
// - opcode 90 loads 16-bit data pointer; three bytes, two cycles.
// - code byte read at accumulator plus data pointer or program counter.
// - external byte read via pointer register 1 (E3) or data pointer, two cycles; EB decodes as a bank register load.
// - accumulator written externally via pointer register or data pointer.
// - C0 pushes and D0 pops a direct byte; two bytes, two cycles.
// - accumulator traded with register, direct byte or indirect location.
// - D6/D7 trade only the low digit with an indirect location.
// - register rows use low nibble 8..F for bank register 0..7.
// - indirect forms point through register 0 or 1, chosen by opcode bit 0.
// - an immediate operand is one byte inside the instruction.
// - a 16-bit constant occupies instruction bytes two and three.
`timescale 1ns/1ns
module ltd_decoder
  import ltd_pkg::*;
#(
  parameter int unsigned CLKS_PER_CYCLE = MC_CLKS
)
(
  input  wire logic      ref_clk,
  input  wire logic      reset,
  input  wire logic      in_valid,
  input  wire ltd_insn_t insn,
  input  wire ltd_opnd_t opnd,
  output logic           in_ready,
  output logic           out_valid,
  output ltd_dec_t       dec,
  output ltd_res_t       res
);

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } ltd_state_t;

  localparam int unsigned CNT_W = 4;

  initial
  begin
    if (CLKS_PER_CYCLE < 1 || 2 * CLKS_PER_CYCLE > (1 << CNT_W))
      $error("ltd_decoder: CLKS_PER_CYCLE out of range");
  end

  // one decoded form; every unlisted opcode comes out not legal
  function automatic ltd_dec_t decode(input ltd_insn_t i);
    ltd_dec_t d;
    logic [3:0] row;
    logic [3:0] col;
    d          = '0;
    d.legal    = 1'b1;
    d.len      = 2'd1;
    d.cycles   = 2'd1;
    d.alu_op   = ALU_PASS;
    d.src      = LOC_NONE;
    d.dst      = LOC_NONE;
    d.bank_idx = i.opcode[2:0];
    d.ptr_sel  = i.opcode[0];
    d.src_addr = i.byte2;
    d.dst_addr = i.byte2;
    d.imm      = i.byte2;
    row        = i.opcode[7:4];
    col        = i.opcode[3:0];
    if (row == ROW_AND || row == ROW_OR || row == ROW_XOR)
    begin
      d.alu_op = (row == ROW_AND) ? ALU_AND :
                 (row == ROW_OR)  ? ALU_OR  : ALU_XOR;
      d.dst    = LOC_ACC;
      if (col[3])
        d.src = LOC_BANK;
      else if (col[3:1] == COL_IND_HI)
        d.src = LOC_IND;
      else if (col == COL_ACC_DIR)
      begin
        d.src = LOC_DIR;
        d.len = 2'd2;
      end
      else if (col == COL_ACC_IMM)
      begin
        d.src = LOC_IMM;
        d.len = 2'd2;
      end
      else if (col == COL_DIR_ACC)
      begin
        d.src = LOC_ACC;
        d.dst = LOC_DIR;
        d.len = 2'd2;
      end
      else if (col == COL_DIR_IMM)
      begin
        d.src    = LOC_IMM;
        d.dst    = LOC_DIR;
        d.imm    = i.byte3;
        d.len    = 2'd3;
        d.cycles = 2'd2;
      end
      else
        d.legal = 1'b0;
    end
    else if (col[3] && row == ROW_LOAD_ACC)
    begin
      d.src = LOC_BANK;
      d.dst = LOC_ACC;
    end
    else if (col[3] && row == ROW_STORE)
    begin
      d.src = LOC_ACC;
      d.dst = LOC_BANK;
    end
    else if (col[3] && row == ROW_DIR_REG)
    begin
      d.src    = LOC_DIR;
      d.dst    = LOC_BANK;
      d.len    = 2'd2;
      d.cycles = 2'd2;
    end
    else if (col[3] && row == ROW_IMM_REG)
    begin
      d.src = LOC_IMM;
      d.dst = LOC_BANK;
      d.len = 2'd2;
    end
    else if (col[3] && row == ROW_REG_DIR)
    begin
      d.src    = LOC_BANK;
      d.dst    = LOC_DIR;
      d.len    = 2'd2;
      d.cycles = 2'd2;
    end
    else if (col[3] && row == ROW_TRADE)
    begin
      d.alu_op = ALU_TRADE;
      d.src    = LOC_BANK;
      d.dst    = LOC_BANK;
    end
    else
    begin
      case (i.opcode)
        OP_ZERO_ACC:  d.alu_op = ALU_ZERO;
        OP_INV_ACC:   d.alu_op = ALU_INV;
        OP_SWAP_ACC:  d.alu_op = ALU_SWAP;
        OP_RL:        d.alu_op = ALU_RL;
        OP_RLC:       d.alu_op = ALU_RLC;
        OP_RR:        d.alu_op = ALU_RR;
        OP_RRC:       d.alu_op = ALU_RRC;
        OP_LOAD_DIR:
        begin
          d.src   = LOC_DIR;
          d.len   = 2'd2;
          d.legal = (i.byte2 != ACC_DIRECT_ADDR);
        end
        OP_LOAD_IMM:
        begin
          d.src = LOC_IMM;
          d.len = 2'd2;
        end
        OP_DIR_ACC:
        begin
          d.src = LOC_ACC;
          d.dst = LOC_DIR;
          d.len = 2'd2;
        end
        OP_DIR_DIR:
        begin
          d.src      = LOC_DIR;
          d.dst      = LOC_DIR;
          d.dst_addr = i.byte3;
          d.len      = 2'd3;
          d.cycles   = 2'd2;
        end
        OP_DIR_IMM:
        begin
          d.src    = LOC_IMM;
          d.dst    = LOC_DIR;
          d.imm    = i.byte3;
          d.len    = 2'd3;
          d.cycles = 2'd2;
        end
        OP_DATA_POINTER16_IMM:
        begin
          d.src    = LOC_IMM;
          d.dst    = LOC_DATA_POINTER16;
          d.len    = 2'd3;
          d.cycles = 2'd2;
        end
        OP_CODE_DATA_POINTER16, OP_CODE_PC:
        begin
          d.src    = LOC_CODE;
          d.cycles = 2'd2;
        end
        OP_EXT_RD_R0, OP_EXT_RD_R1:
        begin
          d.src     = LOC_EXT8;
          d.ptr_sel = (i.opcode == OP_EXT_RD_R0) ? 1'b0 : 1'b1;
          d.cycles  = 2'd2;
        end
        OP_EXT_RD_DP:
        begin
          d.src    = LOC_EXT16;
          d.cycles = 2'd2;
        end
        OP_EXT_WR_DP:
        begin
          d.src    = LOC_ACC;
          d.dst    = LOC_EXT16;
          d.cycles = 2'd2;
        end
        OP_PUSH:
        begin
          d.src    = LOC_DIR;
          d.dst    = LOC_STACK;
          d.len    = 2'd2;
          d.cycles = 2'd2;
        end
        OP_POP:
        begin
          d.src    = LOC_STACK;
          d.dst    = LOC_DIR;
          d.len    = 2'd2;
          d.cycles = 2'd2;
        end
        OP_TRADE_DIR:
        begin
          d.alu_op = ALU_TRADE;
          d.src    = LOC_DIR;
          d.dst    = LOC_DIR;
          d.len    = 2'd2;
        end
        default:
        begin
          case (i.opcode[7:1])
            OP_DIR_IND:
            begin
              d.src    = LOC_IND;
              d.dst    = LOC_DIR;
              d.len    = 2'd2;
              d.cycles = 2'd2;
            end
            OP_IND_ACC:
            begin
              d.src = LOC_ACC;
              d.dst = LOC_IND;
            end
            OP_IND_DIR:
            begin
              d.src    = LOC_DIR;
              d.dst    = LOC_IND;
              d.len    = 2'd2;
              d.cycles = 2'd2;
            end
            OP_IND_IMM:
            begin
              d.src = LOC_IMM;
              d.dst = LOC_IND;
              d.len = 2'd2;
            end
            OP_EXT_WR_RI:
            begin
              d.src    = LOC_ACC;
              d.dst    = LOC_EXT8;
              d.cycles = 2'd2;
            end
            OP_TRADE_IND:
            begin
              d.alu_op = ALU_TRADE;
              d.src    = LOC_IND;
              d.dst    = LOC_IND;
            end
            OP_DIGIT_IND:
            begin
              d.alu_op = ALU_DIGIT;
              d.src    = LOC_IND;
              d.dst    = LOC_IND;
            end
            // accumulator is filled in below as the destination
            OP_LOAD_IND:  d.src = LOC_IND;
            default:      d.legal = 1'b0;
          endcase
        end
      endcase
      // accumulator is the destination of a legal form unless a form above named another
      if (d.dst == LOC_NONE && d.legal)
        d.dst = LOC_ACC;
    end
    return d;
  endfunction : decode

  ltd_state_t        state_ff;
  logic [CNT_W-1:0]  cnt_ff;
  logic              out_valid_ff;
  ltd_dec_t          dec_ff;
  ltd_res_t          res_ff;
  ltd_dec_t          cur;
  logic [7:0]        alu_a;
  logic [7:0]        alu_b;
  logic [7:0]        alu_y;
  logic [7:0]        alu_back;
  logic              alu_c;
  ltd_res_t          nxt_res;
  logic              take;

  assign cur      = decode(insn);
  assign in_ready = (state_ff == ST_IDLE);
  assign take     = in_valid && in_ready;

  // logic into a direct byte works on the byte, everything else on the accumulator
  assign alu_a = (cur.dst == LOC_DIR && cur.alu_op != ALU_PASS
                  && cur.alu_op != ALU_TRADE) ? opnd.dst_val : opnd.acc;
  assign alu_b = (cur.src == LOC_ACC) ? opnd.acc :
                 (cur.src == LOC_IMM) ? cur.imm : opnd.src_val;

  ltd_alu u_alu (
    .op        (cur.alu_op),
    .a         (alu_a),
    .b         (alu_b),
    .carry_in  (opnd.carry),
    .result    (alu_y),
    .back      (alu_back),
    .carry_out (alu_c)
  );

  always_comb
  begin
    nxt_res           = '0;
    nxt_res.acc_val   = alu_y;
    nxt_res.dst_val   = alu_y;
    nxt_res.carry_val = alu_c;
    nxt_res.carry_we  = cur.legal && (cur.alu_op == ALU_RLC || cur.alu_op == ALU_RRC);
    nxt_res.data_pointer16_val  = {insn.byte2, insn.byte3};
    case (cur.src)
      LOC_CODE:  nxt_res.mem_addr = ((insn.opcode == OP_CODE_DATA_POINTER16) ? opnd.data_pointer16 : opnd.pc)
                                    + {8'h00, opnd.acc};
      LOC_EXT8:  nxt_res.mem_addr = {8'h00, opnd.ptr_val};
      LOC_EXT16: nxt_res.mem_addr = opnd.data_pointer16;
      default:   nxt_res.mem_addr = 16'h0000;
    endcase
    if (cur.dst == LOC_EXT8)
      nxt_res.mem_addr = {8'h00, opnd.ptr_val};
    else if (cur.dst == LOC_EXT16)
      nxt_res.mem_addr = opnd.data_pointer16;
    if (cur.legal)
    begin
      if (cur.alu_op == ALU_TRADE || cur.alu_op == ALU_DIGIT)
      begin
        nxt_res.acc_we  = 1'b1;
        nxt_res.dst_we  = 1'b1;
        nxt_res.dst_val = alu_back;
      end
      else if (cur.dst == LOC_DATA_POINTER16)
        nxt_res.data_pointer16_we = 1'b1;
      else if (cur.dst == LOC_ACC)
        nxt_res.acc_we = 1'b1;
      else
      begin
        nxt_res.dst_we  = 1'b1;
        nxt_res.dst_val = (cur.alu_op == ALU_PASS) ? alu_b : alu_y;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
    end
    else if (take)
    begin
      state_ff <= ST_EXEC;
      cnt_ff   <= CNT_W'(cur.cycles * CLKS_PER_CYCLE - 1);
    end
    else if (state_ff == ST_EXEC)
    begin
      if (cnt_ff == '0)
        state_ff <= ST_IDLE;
      else
        cnt_ff <= cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      out_valid_ff <= 1'b0;
    else
      out_valid_ff <= (state_ff == ST_EXEC) && (cnt_ff == '0);
  end

  // results are captured at the take; the caller may change inputs afterwards
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      dec_ff <= '0;
      res_ff <= '0;
    end
    else if (take)
    begin
      dec_ff <= cur;
      res_ff <= nxt_res;
    end
  end

  assign out_valid = out_valid_ff;
  assign dec       = dec_ff;
  assign res       = res_ff;

endmodule : ltd_decoder

/* File: ltd_decoder_asserts.sv */
/*
  concurrent checks on the ports of the decoder.
  assumes it is bound to ltd_decoder and sees only that module's ports.
*/
`timescale 1ns/1ns
module ltd_decoder_asserts
  import ltd_pkg::*;
#(
  parameter int unsigned CLKS_PER_CYCLE = MC_CLKS
)
(
  input wire logic      ref_clk,
  input wire logic      reset,
  input wire logic      in_valid,
  input wire ltd_insn_t insn,
  input wire ltd_opnd_t opnd,
  input wire logic      in_ready,
  input wire logic      out_valid,
  input wire ltd_dec_t  dec,
  input wire ltd_res_t  res
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // cycle figures below hold for one clock per machine cycle only
  sequence s_take;
    in_valid && in_ready;
  endsequence

  sequence s_take_op(logic [7:0] op);
    s_take ##0 insn.opcode == op;
  endsequence

  a_one_cycle_done: assert property (s_take ##1 dec.cycles == 2'd1 |=> out_valid)
    else $error("one-cycle instruction did not finish");
  a_two_cycle_done: assert property (s_take ##1 dec.cycles == 2'd2
    |-> !out_valid ##1 !out_valid ##1 out_valid)
    else $error("two-cycle instruction finished at the wrong edge");
  a_busy_after_take: assert property (s_take |=> !in_ready)
    else $error("ready stayed high after a take");
  a_result_holds: assert property (out_valid && !(in_valid && in_ready) |=> $stable(res))
    else $error("result changed without a new instruction");
  a_data_pointer16_bytes: assert property (s_take_op(8'h90) |-> ##3 (out_valid && res.data_pointer16_we
    && res.data_pointer16_val == {$past(insn.byte2, 3), $past(insn.byte3, 3)}))
    else $error("pointer load took the wrong bytes or time");
  a_acc_self_load: assert property (s_take_op(8'hE5) ##0 insn.byte2 == ACC_DIRECT_ADDR
    |=> (!dec.legal && !res.acc_we) ##1 out_valid)
    else $error("self load of the accumulator was not refused");
  a_zero_acc: assert property (s_take_op(OP_ZERO_ACC) |=> (res.acc_we
    && res.acc_val == 8'h00) ##1 out_valid)
    else $error("accumulator not zeroed");
  a_invert_acc: assert property (s_take_op(OP_INV_ACC) |=> res.acc_val == ~$past(opnd.acc))
    else $error("accumulator not inverted");
  a_carry_rotate_only: assert property (s_take
    |=> res.carry_we == ($past(insn.opcode) inside {8'h33, 8'h13}))
    else $error("carry write on the wrong opcode");
  a_trade_both: assert property (s_take_op(OP_TRADE_DIR) |=> res.acc_we && res.dst_we
    && res.dst_val == $past(opnd.acc) && res.acc_val == $past(opnd.src_val))
    else $error("trade did not update both operands");
endmodule : ltd_decoder_asserts

bind ltd_decoder ltd_decoder_asserts #(.CLKS_PER_CYCLE(CLKS_PER_CYCLE)) u_chk (
  .ref_clk(ref_clk), .reset(reset), .in_valid(in_valid), .insn(insn), .opnd(opnd),
  .in_ready(in_ready), .out_valid(out_valid), .dec(dec), .res(res));

/* File: ltd_prog_mem.sv */
/*
  program memory model holding the test program, one instruction a word.
  assumes fetch is held until ack; slow adds two wait cycles.
*/
`timescale 1ns/1ns
module ltd_prog_mem
  import ltd_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       fetch,
  input  wire logic [4:0] addr,
  input  wire logic       slow,
  output ltd_insn_t       insn,
  output logic            ack
);
  ltd_insn_t  rom [23];
  ltd_insn_t  last_ff;
  logic [1:0] wait_ff;

  // operands follow the opcode; a 16-bit constant sends its high byte first
  initial rom = '{24'h5D_0000, 24'h56_0000, 24'h54_0F00, 24'h4F_0000, 24'h65_3000, 24'h53_30F0,
                  24'h62_4000, 24'h43_4081, 24'hE4_0000, 24'hF4_0000, 24'hC4_0000, 24'h33_0000,
                  24'h13_0000, 24'h23_0000, 24'h03_0000, 24'h90_1234, 24'h85_2030, 24'hE5_E000,
                  24'h93_0000, 24'hC5_2000, 24'hD7_0000, 24'hF7_0000,
                  24'hE6_0000};

  always_ff @(posedge ref_clk)
    if (!fetch) wait_ff <= 2'd0;
    else if (!ack) wait_ff <= wait_ff + 2'd1;

  assign ack = fetch && (wait_ff == (slow ? 2'd3 : 2'd1));

  always_ff @(posedge ref_clk)
    if (ack) last_ff <= rom[addr];

  // off the handshake the bus shows the inverse of the last word, never a stale copy
  assign insn = ack ? rom[addr] : ~last_ff;
endmodule : ltd_prog_mem

/* File: ltd_decoder_test.sv */
/*
  self-checking bench of the decoder, fed from the program memory model.
  assumes one clock per machine cycle and fixed operand values.
*/
`timescale 1ns/1ns
module ltd_decoder_test
  import ltd_pkg::*;
;
  logic        ref_clk  = 1'b0;
  logic        reset    = 1'b1;
  logic        in_valid = 1'b0;
  logic        fetch    = 1'b0;
  logic        slow     = 1'b0;
  logic [4:0]  pc_idx   = 5'd0;
  ltd_insn_t   insn     = '0;
  ltd_opnd_t   opnd     = '{8'hC6, 1'b1, 8'h5A, 8'h3C, 8'h10, 16'h1200, 16'h0100};
  ltd_insn_t   pm_insn;
  logic        in_ready, out_valid, pm_ack;
  ltd_dec_t    dec;
  ltd_res_t    res;
  int          n_mismatch = 0;
  int          num_checks = 0;
  logic [7:0]  ev [23] = '{8'h42, 8'h42, 8'h06, 8'hDE, 8'h9C, 8'h30, 8'hFA, 8'hBD, 8'h00,
                           8'h39, 8'h6C, 8'h8D, 8'hE3, 8'h8D, 8'h63, 8'h00, 8'h5A, 8'h00,
                           8'h5A, 8'h5A, 8'hCA, 8'hC6, 8'h5A};
  logic [22:0] dst_sel = 23'h21_00E0;
  logic [22:0] skip    = 23'h2_8000;
  logic [22:0] two_cyc = 23'h5_80A0;

  always #10 ref_clk = ~ref_clk;

  ltd_decoder dut (.ref_clk(ref_clk), .reset(reset), .in_valid(in_valid), .insn(insn),
    .opnd(opnd), .in_ready(in_ready), .out_valid(out_valid), .dec(dec), .res(res));
  ltd_prog_mem pm (.ref_clk(ref_clk), .fetch(fetch), .addr(pc_idx), .slow(slow),
    .insn(pm_insn), .ack(pm_ack));

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_for(ref logic sig);
    int k;
    k = 0;
    while (sig !== 1'b1 && k < 9)
    begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= 9)
    begin
      n_mismatch++;
      $display("MISMATCH %0t wait ran out", $time);
      conclude();
    end
  endtask : wait_for

  task automatic run(input int i, input logic slw);
    time t0;
    @(negedge ref_clk);
    pc_idx = i[4:0];
    slow = slw;
    fetch = 1'b1;
    wait_for(pm_ack);
    insn = pm_insn;
    in_valid = 1'b1;
    wait_for(in_ready);
    // fetch stays up through the edge that sees ack, which is also the take
    @(negedge ref_clk);
    fetch = 1'b0;
    in_valid = 1'b0;
    t0 = $time;
    wait_for(out_valid);
    chk(16'(($time - t0) / 20), 16'(1 + two_cyc[i]));
    if (dst_sel[i]) chk(res.dst_val, ev[i]);
    else if (!skip[i]) chk(res.acc_val, ev[i]);
  endtask : run

  task automatic sc_logic;
    for (int i = 0; i < 8; i++)
    begin
      run(i, 1'b0);
      if (i == 0) chk(dec.bank_idx, 3'd5);
      if (i == 1) chk(dec.ptr_sel, 1'b0);
      if (i == 5) chk(dec.dst_addr, 8'h30);
      if (i == 7) chk(dec.len, 2'd3);
    end
  endtask : sc_logic

  // slow memory here, so the decoder idles between instructions
  task automatic sc_acc_ops;
    for (int i = 8; i < 15; i++)
    begin
      run(i, 1'b1);
      if (i == 11) chk({res.carry_we, res.carry_val}, 2'b11);
      if (i == 12) chk({res.carry_we, res.carry_val}, 2'b10);
      if (i == 13) chk(res.carry_we, 1'b0);
    end
  endtask : sc_acc_ops

  task automatic sc_transfers;
    for (int i = 15; i < 23; i++)
    begin
      run(i, 1'b0);
      if (i == 15) chk(res.data_pointer16_val, 16'h1234);
      if (i == 16) chk({dec.src_addr, dec.dst_addr}, 16'h2030);
      if (i == 17) chk({dec.legal, res.acc_we}, 2'b00);
      if (i == 18) chk(res.mem_addr, 16'h12C6);
      if (i == 19) chk(res.dst_val, 8'hC6);
      if (i == 20) chk(res.dst_val, 8'h56);
      if (i == 21) chk({dec.ptr_sel, res.acc_we}, 2'b10);
      if (i == 22) chk({dec.src, dec.ptr_sel}, {LOC_IND, 1'b0});
    end
  endtask : sc_transfers

  // a reset after a finished run must wipe a held pointer result
  task automatic sc_reset;
    run(15, 1'b0);
    @(negedge ref_clk);
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk({out_valid, res.data_pointer16_val[14:0]}, 16'h0000);
    chk(in_ready, 1'b1);
    reset = 1'b0;
  endtask : sc_reset

  initial
  begin
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    sc_logic();
    sc_acc_ops();
    sc_transfers();
    sc_reset();
    conclude();
  end
endmodule : ltd_decoder_test
